// [hw/rah_pkg.sv]
package rah_pkg;

  // ----------------------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------------------

  // Byte address of the alarm and hold control register.
  localparam logic [15:0] ALARM_HOLD_CONTROL_ADDR = 16'hff8a;

  // Value of the control register after reset.
  localparam logic [7:0]  ALARM_HOLD_CONTROL_RST  = 8'h00;

  // ----------------------------------------------------------------------------
  // Field positions inside the control register.
  // ----------------------------------------------------------------------------

  localparam int unsigned BIT_ALARM_MATCH_ENABLE = 7;
  localparam int unsigned BIT_ALARM_IRQ_ENABLE   = 6;
  localparam int unsigned BIT_RESERVED_HI        = 5;
  localparam int unsigned BIT_ALARM_MATCH_FLAG   = 4;
  localparam int unsigned BIT_PERIODIC_IRQ_FLAG  = 3;
  localparam int unsigned BIT_RESERVED_LO        = 2;
  localparam int unsigned BIT_HOLD_STATUS        = 1;
  localparam int unsigned BIT_HOLD_REQUEST       = 0;

  // ----------------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------------

  // Rate of the counting clock, delivered as a one-cycle tick on the system clock.
  localparam int unsigned COUNT_CLK_HZ  = 32768;

  // System clock rate.
  localparam int unsigned SYS_CLK_HZ    = 50000000;

  // System clock cycles between two counting ticks, rounded down.
  localparam int unsigned TICK_CYCLES   = SYS_CLK_HZ / COUNT_CLK_HZ;

  // Counting ticks from an alarm match to its flag, and longest hold latency.
  localparam int unsigned ALARM_SET_TICKS = 1;
  localparam int unsigned HOLD_MAX_TICKS  = 1;

endpackage : rah_pkg

// [hw/rah_ctl_if.sv]
// ----------------------------------------------------------------------------
// Control and event signals shared by the register block and its helpers.
// ----------------------------------------------------------------------------
interface rah_ctl_if;
  logic tick;       // Counting tick, already gated by the run enable.
  logic run_en;     // Counter run enable.
  logic alarm_en;   // Alarm match enable.
  logic hold_req;   // Hold request from the control register.
  logic secs_wr;    // Seconds counter is being written.
  logic sub_ovf;    // Sub-second counter overflow pulse.
  logic alarm_set;  // Pulse that sets the alarm match flag.
  logic hold_stat;  // Hold has taken effect.
  logic count_hold; // Seconds through years counters are frozen.
  logic secs_inc;   // Pulse that advances the seconds counter.
  logic sub_clr;    // Pulse that clears the sub-second counter.

  modport top (
    output tick, run_en, alarm_en, hold_req, secs_wr, sub_ovf,
    input  alarm_set, hold_stat, count_hold, secs_inc, sub_clr
  );

  modport alarm (
    input  tick, alarm_en,
    output alarm_set
  );

  modport hold (
    input  tick, run_en, hold_req, secs_wr, sub_ovf,
    output hold_stat, count_hold, secs_inc, sub_clr
  );
endinterface : rah_ctl_if

// [hw/rah_alarm_det.sv]
module rah_alarm_det #(
  parameter int unsigned MW = 8,
  parameter int unsigned HW = 8,
  parameter int unsigned WW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  rah_ctl_if.alarm           ctl,
  input  wire logic [MW-1:0] cur_minute_i,
  input  wire logic [HW-1:0] cur_hour_i,
  input  wire logic [WW-1:0] cur_weekday_i,
  input  wire logic [MW-1:0] alarm_minute_setting_i,
  input  wire logic [HW-1:0] alarm_hour_setting_i,
  input  wire logic [WW-1:0] alarm_weekday_setting_i
);

  logic eq;
  logic prev_r, prev_nxt;
  logic pend_r, pend_nxt;
  logic set_r,  set_nxt;

  // ----------------------------------------------------------------------------
  // Match detection, sampled on counting ticks.
  // ----------------------------------------------------------------------------

  // A new match is the first tick on which the time equals the alarm setting.
  // The flag is set on the following tick, and only while matching is enabled.
  always_comb begin
    eq       = ctl.alarm_en &&
               (cur_minute_i == alarm_minute_setting_i) &&
               (cur_hour_i == alarm_hour_setting_i) &&
               (cur_weekday_i == alarm_weekday_setting_i);
    prev_nxt = ctl.tick ? eq : prev_r;
    pend_nxt = ctl.tick ? (eq && !prev_r) : pend_r;
    set_nxt  = ctl.tick && pend_r && ctl.alarm_en;
  end

  // Registers of the detector.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= 1'b0;
      pend_r <= 1'b0;
      set_r  <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
      set_r  <= set_nxt;
    end
  end

  assign ctl.alarm_set = set_r;

endmodule : rah_alarm_det

// [hw/rah_hold_ctl.sv]
module rah_hold_ctl (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  rah_ctl_if.hold   ctl
);

  logic stat_r, stat_nxt;
  logic hold_r, hold_nxt;
  logic pend_r, pend_nxt;
  logic inc_r,  inc_nxt;
  logic clr_r,  clr_nxt;

  // ----------------------------------------------------------------------------
  // Hold handshake and deferred seconds increment.
  // ----------------------------------------------------------------------------

  // The freeze follows the request one clock later; the status rises on the next tick.
  // An overflow seen while frozen is kept and applied on release, unless the
  // seconds counter is written, which clears the sub-second counter instead.
  always_comb begin
    hold_nxt = ctl.hold_req;
    stat_nxt = ctl.hold_req && (stat_r || ctl.tick);
    pend_nxt = pend_r;
    if (ctl.secs_wr) begin
      pend_nxt = 1'b0;
    end else if (ctl.hold_req && ctl.sub_ovf) begin
      pend_nxt = 1'b1;
    end else if (!ctl.hold_req) begin
      pend_nxt = 1'b0;
    end
    inc_nxt  = ctl.run_en && !ctl.hold_req && !ctl.secs_wr &&
               (ctl.sub_ovf || pend_r);
    clr_nxt  = ctl.secs_wr;
  end

  // Registers of the hold logic.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_r <= 1'b0;
      hold_r <= 1'b0;
      pend_r <= 1'b0;
      inc_r  <= 1'b0;
      clr_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      hold_r <= hold_nxt;
      pend_r <= pend_nxt;
      inc_r  <= inc_nxt;
      clr_r  <= clr_nxt;
    end
  end

  assign ctl.hold_stat  = stat_r;
  assign ctl.count_hold = hold_r;
  assign ctl.secs_inc   = inc_r;
  assign ctl.sub_clr    = clr_r;

endmodule : rah_hold_ctl

// [hw/rah_top.sv]
// How it works
// - Alarm matching happens only while the match enable bit is set.
// - Alarm interrupt enable decides whether an alarm match raises the interrupt.
// - Alarm flag sets one counting tick after a match, only when enabled.
// - Writing 0 clears either flag; writing 1 leaves it as it is.
// - Every periodic event sets the periodic flag.
// - Hold status reads 1 once hold has taken effect, else 0.
// - Hold request freezes seconds through years; clearing it resumes counting.
// - Hold status rises within one counting tick of the request.
// - Overflow during hold is kept and applied after hold ends.
// - Writing seconds during hold clears sub-second and drops pending increment.
// - Alarm and periodic events share one interrupt; flags tell the cause.
// - Counters advance only while the run enable is set.
module rah_top #(
  parameter int unsigned MW = 8,
  parameter int unsigned HW = 8,
  parameter int unsigned WW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic [15:0]   bus_addr_i,
  input  wire logic [7:0]    bus_wdata_i,
  input  wire logic          bus_wr_i,
  input  wire logic          bus_rd_i,
  output logic      [7:0]    bus_rdata_o,
  input  wire logic          rtc_tick_i,
  input  wire logic          counter_run_enable_i,
  input  wire logic          periodic_event_i,
  input  wire logic          seconds_write_i,
  input  wire logic          subsecond_ovf_i,
  input  wire logic [MW-1:0] cur_minute_i,
  input  wire logic [HW-1:0] cur_hour_i,
  input  wire logic [WW-1:0] cur_weekday_i,
  input  wire logic [MW-1:0] alarm_minute_setting_i,
  input  wire logic [HW-1:0] alarm_hour_setting_i,
  input  wire logic [WW-1:0] alarm_weekday_setting_i,
  output logic               shared_rtc_interrupt_o,
  output logic               alarm_match_flag_o,
  output logic               periodic_irq_flag_o,
  output logic               hold_status_o,
  output logic               count_hold_o,
  output logic               seconds_incr_o,
  output logic               subsecond_clear_o
);

  // ----------------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------------

  rah_ctl_if ctl ();

  logic       reg_sel;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_view;

  logic       alarm_match_enable_r, alarm_match_enable_nxt;
  logic       alarm_irq_enable_r,   alarm_irq_enable_nxt;
  logic       hold_request_r,       hold_request_nxt;
  logic       alarm_match_flag_r,   alarm_match_flag_nxt;
  logic       periodic_irq_flag_r,  periodic_irq_flag_nxt;
  logic       irq_r,                irq_nxt;
  logic [7:0] rdata_r,              rdata_nxt;

  // ----------------------------------------------------------------------------
  // Register access decode.
  // ----------------------------------------------------------------------------

  // The register answers only its own byte address; other addresses read zero.
  assign reg_sel = (bus_addr_i == rah_pkg::ALARM_HOLD_CONTROL_ADDR);
  assign reg_wr  = reg_sel && bus_wr_i;
  assign reg_rd  = reg_sel && bus_rd_i;

  // Current register contents as software sees them.
  always_comb begin
    reg_view = 8'h00;
    reg_view[rah_pkg::BIT_ALARM_MATCH_ENABLE] = alarm_match_enable_r;
    reg_view[rah_pkg::BIT_ALARM_IRQ_ENABLE]   = alarm_irq_enable_r;
    reg_view[rah_pkg::BIT_ALARM_MATCH_FLAG]   = alarm_match_flag_r;
    reg_view[rah_pkg::BIT_PERIODIC_IRQ_FLAG]  = periodic_irq_flag_r;
    reg_view[rah_pkg::BIT_HOLD_STATUS]        = ctl.hold_stat;
    reg_view[rah_pkg::BIT_HOLD_REQUEST]       = hold_request_r;
  end

  // ----------------------------------------------------------------------------
  // Control bits written by software.
  // ----------------------------------------------------------------------------

  // Enables and the hold request take the written value; reserved and hold status
  // positions of the write data are ignored.
  always_comb begin
    alarm_match_enable_nxt = alarm_match_enable_r;
    alarm_irq_enable_nxt   = alarm_irq_enable_r;
    hold_request_nxt       = hold_request_r;
    if (reg_wr) begin
      alarm_match_enable_nxt = bus_wdata_i[rah_pkg::BIT_ALARM_MATCH_ENABLE];
      alarm_irq_enable_nxt   = bus_wdata_i[rah_pkg::BIT_ALARM_IRQ_ENABLE];
      hold_request_nxt       = bus_wdata_i[rah_pkg::BIT_HOLD_REQUEST];
    end
  end

  // Registers of the control bits.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_match_enable_r <= rah_pkg::ALARM_HOLD_CONTROL_RST[rah_pkg::BIT_ALARM_MATCH_ENABLE];
      alarm_irq_enable_r   <= rah_pkg::ALARM_HOLD_CONTROL_RST[rah_pkg::BIT_ALARM_IRQ_ENABLE];
      hold_request_r       <= rah_pkg::ALARM_HOLD_CONTROL_RST[rah_pkg::BIT_HOLD_REQUEST];
    end else begin
      alarm_match_enable_r <= alarm_match_enable_nxt;
      alarm_irq_enable_r   <= alarm_irq_enable_nxt;
      hold_request_r       <= hold_request_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Status flags.
  // ----------------------------------------------------------------------------

  // Hardware sets, software clears by writing 0. A set arriving in the same
  // cycle as a clearing write wins, so no event is lost.
  always_comb begin
    alarm_match_flag_nxt  = alarm_match_flag_r;
    periodic_irq_flag_nxt = periodic_irq_flag_r;
    if (reg_wr && !bus_wdata_i[rah_pkg::BIT_ALARM_MATCH_FLAG]) begin
      alarm_match_flag_nxt = 1'b0;
    end
    if (reg_wr && !bus_wdata_i[rah_pkg::BIT_PERIODIC_IRQ_FLAG]) begin
      periodic_irq_flag_nxt = 1'b0;
    end
    if (ctl.alarm_set) begin
      alarm_match_flag_nxt = 1'b1;
    end
    if (periodic_event_i) begin
      periodic_irq_flag_nxt = 1'b1;
    end
  end

  // Registers of the status flags.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_match_flag_r  <= rah_pkg::ALARM_HOLD_CONTROL_RST[rah_pkg::BIT_ALARM_MATCH_FLAG];
      periodic_irq_flag_r <= rah_pkg::ALARM_HOLD_CONTROL_RST[rah_pkg::BIT_PERIODIC_IRQ_FLAG];
    end else begin
      alarm_match_flag_r  <= alarm_match_flag_nxt;
      periodic_irq_flag_r <= periodic_irq_flag_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Shared interrupt and read data.
  // ----------------------------------------------------------------------------

  // One interrupt pulse for either cause; the alarm cause is gated by its
  // interrupt enable, the periodic cause is always passed on.
  always_comb begin
    irq_nxt   = (ctl.alarm_set && alarm_irq_enable_r) ||
                periodic_event_i;
    rdata_nxt = reg_rd ? reg_view : 8'h00;
  end

  // Registers of the interrupt pulse and read data.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      irq_r   <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Helper wiring.
  // ----------------------------------------------------------------------------

  // Ticks only count while the run enable is set.
  assign ctl.tick     = rtc_tick_i && counter_run_enable_i;
  assign ctl.run_en   = counter_run_enable_i;
  assign ctl.alarm_en = alarm_match_enable_r;
  assign ctl.hold_req = hold_request_r;
  assign ctl.secs_wr  = seconds_write_i;
  assign ctl.sub_ovf  = subsecond_ovf_i;

  // Alarm match detector.
  rah_alarm_det #(
    .MW (MW),
    .HW (HW),
    .WW (WW)
  ) i_rah_alarm_det (
    .clk_i                   (clk_i),
    .sys_rst_i               (sys_rst_i),
    .ctl                     (ctl),
    .cur_minute_i            (cur_minute_i),
    .cur_hour_i              (cur_hour_i),
    .cur_weekday_i           (cur_weekday_i),
    .alarm_minute_setting_i  (alarm_minute_setting_i),
    .alarm_hour_setting_i    (alarm_hour_setting_i),
    .alarm_weekday_setting_i (alarm_weekday_setting_i)
  );

  // Hold handshake.
  rah_hold_ctl i_rah_hold_ctl (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ctl       (ctl)
  );

  // ----------------------------------------------------------------------------
  // Outputs, each from a flip-flop.
  // ----------------------------------------------------------------------------

  assign bus_rdata_o            = rdata_r;
  assign shared_rtc_interrupt_o = irq_r;
  assign alarm_match_flag_o     = alarm_match_flag_r;
  assign periodic_irq_flag_o    = periodic_irq_flag_r;
  assign hold_status_o          = ctl.hold_stat;
  assign count_hold_o           = ctl.count_hold;
  assign seconds_incr_o         = ctl.secs_inc;
  assign subsecond_clear_o      = ctl.sub_clr;

endmodule : rah_top

// [tb/rah_top_sva.sv]
// ----------------------------------------------------------------------------
// Port-level checks for the alarm and hold control block.
// ----------------------------------------------------------------------------
module rah_top_sva (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0]  bus_wdata_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [7:0]  bus_rdata_o,
  input wire logic        rtc_tick_i,
  input wire logic        counter_run_enable_i,
  input wire logic        periodic_event_i,
  input wire logic        seconds_write_i,
  input wire logic        shared_rtc_interrupt_o,
  input wire logic        alarm_match_flag_o,
  input wire logic        periodic_irq_flag_o,
  input wire logic        hold_status_o,
  input wire logic        count_hold_o,
  input wire logic        seconds_incr_o,
  input wire logic        subsecond_clear_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Marks a bus cycle aimed at the control register.
  wire logic hit = (bus_addr_i == rah_pkg::ALARM_HOLD_CONTROL_ADDR);

  a_periodic_flag_set : assert property (
    periodic_event_i |=> periodic_irq_flag_o && shared_rtc_interrupt_o)
    else $error("periodic event did not set flag and interrupt");
  a_periodic_flag_clr : assert property (
    bus_wr_i && hit && !bus_wdata_i[3] && !periodic_event_i |=> !periodic_irq_flag_o)
    else $error("periodic flag not cleared by zero write");
  // A tick near the write may set the alarm flag, and a set wins over a clear.
  a_alarm_flag_clr : assert property (
    bus_wr_i && hit && !bus_wdata_i[4] && !rtc_tick_i && !$past(rtc_tick_i)
    |=> !alarm_match_flag_o)
    else $error("alarm flag not cleared by zero write");
  a_alarm_on_tick : assert property (
    $rose(alarm_match_flag_o) |-> $past(rtc_tick_i) || $past(rtc_tick_i, 2))
    else $error("alarm flag rose away from a counting tick");
  a_irq_has_cause : assert property (
    shared_rtc_interrupt_o |-> $past(periodic_event_i) || $past(rtc_tick_i)
      || $past(rtc_tick_i, 2))
    else $error("interrupt without periodic event or tick");
  a_hold_follows_wr : assert property (
    bus_wr_i && hit |-> ##2 count_hold_o == $past(bus_wdata_i[0], 2))
    else $error("count hold does not follow hold request write");
  a_hold_within_tick : assert property (
    count_hold_o && rtc_tick_i && counter_run_enable_i && !$past(bus_wr_i && hit)
    |=> hold_status_o)
    else $error("hold status late after a counting tick");
  a_status_needs_hold : assert property (
    hold_status_o |-> count_hold_o)
    else $error("hold status high while counters run");
  a_sec_write_clear : assert property (
    seconds_write_i |=> subsecond_clear_o)
    else $error("seconds write did not clear sub-second counter");
  a_run_stops_count : assert property (
    !counter_run_enable_i |=> !seconds_incr_o)
    else $error("seconds advanced while counting stopped");
  a_reserved_zero : assert property (
    bus_rd_i && hit |=> bus_rdata_o[5] == 1'b0 && bus_rdata_o[2] == 1'b0)
    else $error("reserved bit read back nonzero");
endmodule : rah_top_sva

bind rah_top rah_top_sva i_rah_top_sva (.clk_i, .sys_rst_i, .bus_addr_i, .bus_wdata_i,
  .bus_wr_i, .bus_rd_i, .bus_rdata_o, .rtc_tick_i, .counter_run_enable_i, .periodic_event_i,
  .seconds_write_i, .shared_rtc_interrupt_o, .alarm_match_flag_o, .periodic_irq_flag_o,
  .hold_status_o, .count_hold_o, .seconds_incr_o, .subsecond_clear_o);

// [tb/rah_top_tb.sv]
module rah_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Signals and design instance.
  // --------------------------------------------------------------------------
  localparam logic [15:0] A = rah_pkg::ALARM_HOLD_CONTROL_ADDR;
  logic        clk_i, sys_rst_i, bus_wr_i, bus_rd_i, rtc_tick_i, counter_run_enable_i;
  logic        periodic_event_i, seconds_write_i, subsecond_ovf_i;
  logic [15:0] bus_addr_i;
  logic [7:0]  bus_wdata_i, bus_rdata_o, cur_minute_i, cur_hour_i, cur_weekday_i;
  logic [7:0]  alarm_minute_setting_i, alarm_hour_setting_i, alarm_weekday_setting_i;
  logic        shared_rtc_interrupt_o, alarm_match_flag_o, periodic_irq_flag_o;
  logic        hold_status_o, count_hold_o, seconds_incr_o, subsecond_clear_o;
  logic [7:0]  irq_cnt, inc_cnt, clr_cnt;
  int          n_fail, n_compared, cycles;

  rah_top i_rah_top (.clk_i, .sys_rst_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i,
    .bus_rdata_o, .rtc_tick_i, .counter_run_enable_i, .periodic_event_i, .seconds_write_i,
    .subsecond_ovf_i, .cur_minute_i, .cur_hour_i, .cur_weekday_i, .alarm_minute_setting_i,
    .alarm_hour_setting_i, .alarm_weekday_setting_i, .shared_rtc_interrupt_o,
    .alarm_match_flag_o, .periodic_irq_flag_o, .hold_status_o, .count_hold_o,
    .seconds_incr_o, .subsecond_clear_o);

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Counts one-cycle output pulses and cuts a hung run short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (shared_rtc_interrupt_o === 1'b1) irq_cnt <= irq_cnt + 8'h01;
    if (seconds_incr_o === 1'b1) inc_cnt <= inc_cnt + 8'h01;
    if (subsecond_clear_o === 1'b1) clr_cnt <= clr_cnt + 8'h01;
    if (cycles == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  // --------------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_wr_i    <= 1'b1;
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data is registered, so it is judged just after the edge that takes the read.
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus_rd_i   <= 1'b1;
    bus_addr_i <= a;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_rdata_o, exp);
  endtask : rdc

  // Pulses one event input: 0 tick, 1 periodic, 2 seconds write, 3 overflow.
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: rtc_tick_i <= 1'b1;
      1: periodic_event_i <= 1'b1;
      2: seconds_write_i <= 1'b1;
      default: subsecond_ovf_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {rtc_tick_i, periodic_event_i, seconds_write_i, subsecond_ovf_i} <= 4'h0;
    #1;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  task automatic set_min(input logic [7:0] v);
    @(posedge clk_i);
    cur_minute_i <= v;
  endtask : set_min

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic t_regs();
    rdc(A, 8'h00);
    wr(A, 8'hff);
    rdc(A, 8'hc1);
    wr(16'hff89, 8'h18);
    rdc(A, 8'hc1);
    rdc(16'hff89, 8'h00);
    wr(A, 8'h18);
    rdc(A, 8'h00);
  endtask : t_regs

  task automatic t_periodic();
    pulse(1);
    idle(1);
    chk(periodic_irq_flag_o, 8'h01);
    chk(irq_cnt, 8'h01);
    wr(A, 8'h18);
    chk(periodic_irq_flag_o, 8'h01);
    wr(A, 8'h10);
    chk(periodic_irq_flag_o, 8'h00);
  endtask : t_periodic

  // Each match start needs a mismatching tick first, then two ticks to set the flag.
  task automatic alarm_round(input logic [7:0] ctl);
    set_min(8'h01);
    pulse(0);
    wr(A, ctl & 8'h7f);
    wr(A, ctl);
    set_min(8'h00);
    pulse(0);
    pulse(0);
    idle(2);
  endtask : alarm_round

  task automatic t_alarm();
    alarm_round(8'h18);
    chk(alarm_match_flag_o, 8'h00);
    alarm_round(8'hd8);
    chk(alarm_match_flag_o, 8'h01);
    chk(irq_cnt, 8'h02);
    wr(A, 8'hc8);
    chk(alarm_match_flag_o, 8'h00);
    alarm_round(8'h98);
    chk(alarm_match_flag_o, 8'h01);
    chk(irq_cnt, 8'h02);
    wr(A, 8'h88);
    @(posedge clk_i);
    cur_hour_i <= 8'h01;
    alarm_round(8'h88);
    chk(alarm_match_flag_o, 8'h00);
    wr(A, 8'h18);
  endtask : t_alarm

  task automatic t_hold();
    wr(A, 8'h19);
    idle(1);
    chk(count_hold_o, 8'h01);
    pulse(0);
    idle(1);
    chk(hold_status_o, 8'h01);
    rdc(A, 8'h03);
    pulse(3);
    idle(2);
    chk(inc_cnt, 8'h00);
    wr(A, 8'h18);
    idle(3);
    chk(inc_cnt, 8'h01);
    chk(hold_status_o, 8'h00);
    wr(A, 8'h19);
    pulse(3);
    pulse(2);
    idle(1);
    chk(clr_cnt, 8'h01);
    wr(A, 8'h18);
    idle(3);
    chk(inc_cnt, 8'h01);
  endtask : t_hold

  task automatic t_run();
    @(posedge clk_i);
    counter_run_enable_i <= 1'b0;
    pulse(3);
    idle(2);
    chk(inc_cnt, 8'h01);
    @(posedge clk_i);
    counter_run_enable_i <= 1'b1;
    pulse(3);
    idle(2);
    chk(inc_cnt, 8'h02);
  endtask : t_run

  task automatic finish_test();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Main sequence: reset, then every scenario in turn.
  initial begin
    {bus_wr_i, bus_rd_i, rtc_tick_i, periodic_event_i, seconds_write_i} = 5'h00;
    {subsecond_ovf_i, bus_addr_i, bus_wdata_i} = 25'h0000000;
    {cur_hour_i, cur_weekday_i, alarm_minute_setting_i} = 24'h000000;
    {alarm_hour_setting_i, alarm_weekday_setting_i} = 16'h0000;
    {irq_cnt, inc_cnt, clr_cnt} = 24'h000000;
    cur_minute_i = 8'h01;
    counter_run_enable_i = 1'b1;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_periodic();
    t_alarm();
    t_hold();
    t_run();
    finish_test();
  end
endmodule : rah_top_tb
